/* hw/twbf_pkg.sv */
package twbf_pkg;

  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int ADDR_W = 7;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_FALL = 4'h7;
  localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
  localparam logic [3:0] RESERVED_TOP = 4'hF;
  localparam logic DIR_READ = 1'b1;
  localparam logic LINE_LOW = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_RX,
    ST_RX_ACK,
    ST_TX_LOAD,
    ST_TX,
    ST_TX_ACK
  } twbf_state_e;

  typedef struct packed {
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic scl_d;
    logic sda_d;
    twbf_state_e st;
    logic busy;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic gc;
    logic sda_oe;
    logic scl_oe;
    logic push;
  } twbf_core_s;

  typedef struct packed {
    logic [4:0] wr_ptr;
    logic [4:0] rd_ptr;
  } twbf_fifo_s;

endpackage : twbf_pkg

/* hw/twbf_top.sv */
module twbf_fifo import twbf_pkg::*; #(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Fill side
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  // Drain side
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [WIDTH-1:0] rd_data_out
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wr_ptr_reg;
  logic [PW:0] rd_ptr_reg;
  logic [PW:0] wr_ptr_next;
  logic [PW:0] rd_ptr_next;
  logic full;
  logic empty;
  logic do_wr;
  logic do_rd;

  // Extra pointer bit separates full from empty
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign full = (wr_ptr_reg[PW] != rd_ptr_reg[PW]) &&
                (wr_ptr_reg[PW-1:0] == rd_ptr_reg[PW-1:0]);
  assign wr_ready_out = !full;
  assign rd_valid_out = !empty;
  assign rd_data_out = mem[rd_ptr_reg[PW-1:0]];
  assign do_wr = wr_valid_in && !full;
  assign do_rd = rd_ready_in && !empty;

  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    if (do_wr) begin
      wr_ptr_next = wr_ptr_reg + 1'b1;
    end
    if (do_rd) begin
      rd_ptr_next = rd_ptr_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (do_wr) begin
      mem[wr_ptr_reg[PW-1:0]] <= wr_data_in;
    end
  end

endmodule // twbf_fifo

// Summary of operation
// R01: One clock pulse per bit; data steady while clock high, except start/stop.
// R02: Master marks start and stop by moving data while clock is high.
// R03: Bus busy from start until the following stop.
// R04: Repeated start restarts a transfer; bus stays busy until stop.
// R05: Address packet: seven address bits, direction bit, acknowledge bit.
// R06: Direction one means read, zero means write.
// R07: Addressed slave pulls data low in ninth cycle; unable slave leaves high.
// R08: After unacknowledged address master sends stop or repeated start.
// R09: Address sent most significant bit first.
// R10: All-zero address is general call; enabled slaves acknowledge writes.
// R11: Masters never send general call with read direction.
// R12: Addresses with top four bits set are reserved.
// R13: Data packet: byte most significant bit first, then acknowledge.
// R14: Receiver pulls data low in ninth cycle to acknowledge, else not.
// R15: Receiver that cannot take more answers not-acknowledge.
// R16: Master drives clock and conditions; receiver drives acknowledge.
// R17: Transfer needs start, address, data packet and stop.
// R18: Slave may stretch clock low; master waits for release.
// R19: Lines are only pulled low or released to the pull-up.
// R20: Interface disabled while its power-off bit is one.
// R21: Data and acknowledge sampled while clock high, after stretch release.
module twbf_top import twbf_pkg::*; #(
  parameter int RX_DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Configuration
  input wire logic serial_bus_power_off_bit_in,
  input wire logic [ADDR_W-1:0] own_addr_in,
  input wire logic gc_enable_in,
  // Status
  output logic busy_out,
  output logic addressed_out,
  output logic general_call_out,
  // Received byte stream
  output logic rx_valid_out,
  input wire logic rx_ready_in,
  output logic [DATA_W-1:0] rx_data_out,
  // Byte stream to send
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  input wire logic [DATA_W-1:0] tx_data_in
);

  twbf_core_s s_reg;
  twbf_core_s s_next;
  logic scl;
  logic sda;
  logic rise;
  logic fall;
  logic start_det;
  logic stop_det;
  logic fifo_ready;
  logic [ADDR_W-1:0] rx_addr;
  logic addr_hit;
  logic gc_hit;

  twbf_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(RX_DEPTH)
  ) u_rx_fifo (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .wr_valid_in(s_reg.push),
    .wr_ready_out(fifo_ready),
    .wr_data_in(s_reg.sh),
    .rd_valid_out(rx_valid_out),
    .rd_ready_in(rx_ready_in),
    .rd_data_out(rx_data_out)
  );

  // Only the second stage feeds logic
  assign scl = s_reg.scl_sy[1];
  assign sda = s_reg.sda_sy[1];
  // R21: sample edge
  assign rise = scl && !s_reg.scl_d;
  assign fall = !scl && s_reg.scl_d;
  // R02: conditions while clock high
  assign start_det = scl && s_reg.scl_d && s_reg.sda_d && !sda;
  assign stop_det = scl && s_reg.scl_d && !s_reg.sda_d && sda;

  // R05: address and direction split
  assign rx_addr = s_reg.sh[7:1];
  // R12: reserved own address never answers
  assign addr_hit = (rx_addr == own_addr_in) && (own_addr_in[6:3] != RESERVED_TOP);
  // R10: general call only with write
  assign gc_hit = gc_enable_in && (rx_addr == GEN_CALL_ADDR) && (s_reg.sh[0] != DIR_READ);

  // R19: open drain, only low or released
  assign scl_out = LINE_LOW;
  assign sda_out = LINE_LOW;
  assign scl_oe_out = s_reg.scl_oe;
  assign sda_oe_out = s_reg.sda_oe;
  assign busy_out = s_reg.busy;
  assign general_call_out = s_reg.gc;
  assign addressed_out = (s_reg.st != ST_IDLE) && (s_reg.st != ST_ADDR);
  assign tx_ready_out = (s_reg.st == ST_TX_LOAD) && !serial_bus_power_off_bit_in;

  always_comb begin
    s_next = s_reg;
    s_next.scl_sy = {s_reg.scl_sy[0], scl_in};
    s_next.sda_sy = {s_reg.sda_sy[0], sda_in};
    s_next.scl_d = scl;
    s_next.sda_d = sda;
    s_next.push = 1'b0;
    if (serial_bus_power_off_bit_in) begin
      // R20: held idle, lines released
      s_next.st = ST_IDLE;
      s_next.busy = 1'b0;
      s_next.sda_oe = 1'b0;
      s_next.scl_oe = 1'b0;
      s_next.gc = 1'b0;
      s_next.cnt = '0;
    end else if (start_det) begin
      // R04: repeated start resets framing
      s_next.st = ST_ADDR;
      // R03: busy from start
      s_next.busy = 1'b1;
      s_next.cnt = '0;
      s_next.sda_oe = 1'b0;
      s_next.scl_oe = 1'b0;
      s_next.gc = 1'b0;
    end else if (stop_det) begin
      // R03: free after stop
      s_next.st = ST_IDLE;
      s_next.busy = 1'b0;
      s_next.sda_oe = 1'b0;
      s_next.scl_oe = 1'b0;
      s_next.gc = 1'b0;
    end else begin
      case (s_reg.st)
        ST_IDLE: begin
          s_next.sda_oe = 1'b0;
        end
        ST_ADDR: begin
          if (rise) begin
            // R09: first bit lands on top
            s_next.sh = {s_reg.sh[6:0], sda};
            s_next.cnt = s_reg.cnt + 1'b1;
          end else if (fall && s_reg.cnt == BITS_PER_BYTE) begin
            s_next.rw = s_reg.sh[0];
            s_next.gc = gc_hit;
            // R07: acknowledge in ninth cycle or stay off the bus
            if (addr_hit || gc_hit) begin
              s_next.sda_oe = 1'b1;
              s_next.st = ST_ADDR_ACK;
            end else begin
              // R08: wait for stop or repeated start
              s_next.st = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (fall) begin
            s_next.sda_oe = 1'b0;
            s_next.cnt = '0;
            // R06: direction picks the path
            if (s_reg.rw == DIR_READ) begin
              s_next.st = ST_TX_LOAD;
              // R18: stretch until a byte is ready
              s_next.scl_oe = 1'b1;
            end else begin
              s_next.st = ST_RX;
            end
          end
        end
        ST_RX: begin
          if (rise) begin
            // R13: byte shifts in MSB first
            s_next.sh = {s_reg.sh[6:0], sda};
            s_next.cnt = s_reg.cnt + 1'b1;
          end else if (fall && s_reg.cnt == BITS_PER_BYTE) begin
            // R15: full buffer answers not-acknowledge
            s_next.sda_oe = fifo_ready;
            s_next.push = fifo_ready;
            s_next.rw = !fifo_ready;
            s_next.st = ST_RX_ACK;
          end
        end
        ST_RX_ACK: begin
          if (fall) begin
            // R16: receiver releases after its acknowledge
            s_next.sda_oe = 1'b0;
            s_next.cnt = '0;
            s_next.st = s_reg.rw ? ST_IDLE : ST_RX;
          end
        end
        ST_TX_LOAD: begin
          if (tx_valid_in) begin
            s_next.sh = tx_data_in;
            // R13: MSB first on the line
            s_next.sda_oe = !tx_data_in[7];
            s_next.cnt = '0;
            s_next.st = ST_TX;
          end
        end
        ST_TX: begin
          // R18: free clock a cycle after first bit settles
          s_next.scl_oe = 1'b0;
          if (fall) begin
            // R01: data moves only while clock low
            if (s_reg.cnt == LAST_TX_FALL) begin
              s_next.sda_oe = 1'b0;
              s_next.st = ST_TX_ACK;
            end else begin
              s_next.sh = {s_reg.sh[6:0], 1'b0};
              s_next.sda_oe = !s_reg.sh[6];
              s_next.cnt = s_reg.cnt + 1'b1;
            end
          end
        end
        ST_TX_ACK: begin
          if (rise) begin
            // R14: low line is acknowledge
            s_next.rw = !sda;
          end else if (fall) begin
            if (s_reg.rw) begin
              s_next.st = ST_TX_LOAD;
              s_next.scl_oe = 1'b1;
            end else begin
              // Master ended the read; stay off until the next start
              s_next.st = ST_IDLE;
            end
          end
        end
        default: begin
          s_next.st = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_reg <= '{scl_sy: 2'h3, sda_sy: 2'h3, scl_d: 1'b1, sda_d: 1'b1,
                 st: ST_IDLE, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  a_start_busy: assert property (start_det && !serial_bus_power_off_bit_in |=> busy_out) // R03
    else $error("start did not mark bus busy");

  a_stop_free: assert property (stop_det && !start_det |=> !busy_out) // R03
    else $error("stop did not free bus");

  a_power_off_quiet: assert property (serial_bus_power_off_bit_in |=> ##[0:1]
      (!sda_oe_out && !scl_oe_out && !busy_out)) // R20
    else $error("lines driven while powered off");

  a_data_steady: assert property ($changed(sda_oe_out) && !$past(serial_bus_power_off_bit_in)
      && !$past(start_det) && !$past(stop_det) |-> !$past(scl)) // R01
    else $error("data driver changed while clock high");

  a_addr_ack_low: assert property (s_reg.st == ST_ADDR && fall && s_reg.cnt == BITS_PER_BYTE
      && !start_det && !stop_det && !serial_bus_power_off_bit_in
      |=> sda_oe_out == (addr_hit || gc_hit)) // R07
    else $error("address acknowledge wrong");

  a_full_nack: assert property (s_reg.st == ST_RX && fall && s_reg.cnt == BITS_PER_BYTE
      && !fifo_ready && !start_det && !stop_det && !serial_bus_power_off_bit_in
      |=> !sda_oe_out [*2]) // R15
    else $error("full buffer acknowledged a byte");

  a_stretch_hold: assert property (s_reg.st == ST_TX_LOAD && !tx_valid_in
      && !serial_bus_power_off_bit_in && !start_det && !stop_det |=> scl_oe_out) // R18
    else $error("clock released with no byte to send");

  a_msb_first: assert property (tx_ready_out && tx_valid_in && !start_det && !stop_det
      |=> sda_oe_out == !$past(tx_data_in[7]) && s_reg.st == ST_TX) // R13
    else $error("first bit sent is not the top bit");

  a_gc_read_ignored: assert property (s_reg.st == ST_ADDR && fall && s_reg.cnt == BITS_PER_BYTE
      && rx_addr == GEN_CALL_ADDR && s_reg.sh[0] == DIR_READ && own_addr_in != GEN_CALL_ADDR
      |=> !sda_oe_out) // R10
    else $error("general call read acknowledged");

endmodule // twbf_top

/* tb/test_two_wire_bus_framing.sv */
module test_two_wire_bus_framing import twbf_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in, nrst_in, scl_pull, sda_pull, scl_o, scl_oe, sda_o, sda_oe, scl_w, sda_w;
  logic power_off, gc_en, busy, addressed, gcall, rx_valid, rx_ready, tx_valid, tx_ready;
  logic hold_rx;
  logic [6:0] own;
  logic [7:0] rx_data, tx_data;
  logic [7:0] rxq[$];
  logic [7:0] txq[$];
  logic [7:0] rdq[$];
  int errors, num_checks;
  // Wired AND with pull-ups
  assign scl_w = !((scl_oe && !scl_o) || scl_pull);
  assign sda_w = !((sda_oe && !sda_o) || sda_pull);
  twbf_master m (.clk_in(clk_in), .scl_line_in(scl_w), .sda_line_in(sda_w),
    .scl_pull_out(scl_pull), .sda_pull_out(sda_pull));
  twbf_top #(.RX_DEPTH(16)) dut (.clk_in(clk_in), .nrst_in(nrst_in), .scl_in(scl_w),
    .scl_out(scl_o), .scl_oe_out(scl_oe), .sda_in(sda_w), .sda_out(sda_o),
    .sda_oe_out(sda_oe), .serial_bus_power_off_bit_in(power_off), .own_addr_in(own),
    .gc_enable_in(gc_en), .busy_out(busy), .addressed_out(addressed),
    .general_call_out(gcall), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready),
    .rx_data_out(rx_data), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
    .tx_data_in(tx_data));
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = !clk_in;
  end
  task automatic test_done();
    if (errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic addr(input logic [6:0] a, input logic dir, input logic ex);
    logic [7:0] r;
    logic k;
    m.xfer({a, dir}, 1'b1, r, k);
    chk(8'(k), 8'(ex));
  endtask
  task automatic wr(input int n, input int acc);
    logic [7:0] d, r;
    logic k;
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      if (i < acc) rxq.push_back(d);
      m.xfer(d, 1'b1, r, k);
      chk(8'(k), 8'(i >= acc));
    end
  endtask
  task automatic drain();
    for (int k = 0; k < 400 && rxq.size() > 0; k++) @(negedge clk_in);
    chk(8'(rxq.size()), 8'h00);
  endtask
  // Receive stream, random stalls
  always @(negedge clk_in) rx_ready <= hold_rx ? 1'b0 : 1'($urandom % 2);
  always @(posedge clk_in) begin
    if (nrst_in && rx_valid === 1'b1 && rx_ready === 1'b1) begin
      if (rxq.size() == 0) chk(8'h01, 8'h00);
      else chk(rx_data, rxq.pop_front());
    end
  end
  // Send stream, slow to offer
  initial begin
    tx_valid = 1'b0;
    tx_data = 8'h00;
    forever begin
      @(negedge clk_in);
      if (tx_ready === 1'b1 && txq.size() > 0) begin
        repeat ($urandom % 8) @(negedge clk_in);
        tx_data = txq[0];
        tx_valid = 1'b1;
        @(posedge clk_in);
        if (tx_ready) void'(txq.pop_front());
        @(negedge clk_in);
        tx_valid = 1'b0;
      end
    end
  end
  initial begin
    repeat (60000) @(posedge clk_in);
    errors++;
    test_done();
  end
  initial begin
    logic [7:0] r;
    logic k;
    void'($urandom(7037));
    nrst_in = 1'b0;
    power_off = 1'b0;
    gc_en = 1'b0;
    hold_rx = 1'b0;
    own = 7'h10 + 7'($urandom % 96);
    repeat (20) @(posedge clk_in);
    @(negedge clk_in);
    nrst_in = 1'b1;
    m.q(3);
    chk({6'h00, busy, sda_oe}, 8'h00);
    m.start();
    addr(own, 1'b0, 1'b0);
    chk({6'h00, busy, addressed}, 8'h03);
    wr(3, 3);
    m.stop();
    m.q(2);
    chk(8'(busy), 8'h00);
    m.start();
    addr(own ^ 7'h01, 1'b0, 1'b1);
    m.start();
    chk(8'(busy), 8'h01);
    addr(own, 1'b0, 1'b0);
    wr(1, 1);
    gc_en = 1'b1;
    m.start();
    addr(GEN_CALL_ADDR, 1'b0, 1'b0);
    chk(8'(gcall), 8'h01);
    wr(2, 2);
    m.start();
    addr(GEN_CALL_ADDR, DIR_READ, 1'b1);
    gc_en = 1'b0;
    m.start();
    addr(GEN_CALL_ADDR, 1'b0, 1'b1);
    m.stop();
    own = {RESERVED_TOP, 3'($urandom)};
    m.start();
    addr(own, 1'b0, 1'b1);
    m.stop();
    own = 7'h10 + 7'($urandom % 96);
    for (int i = 0; i < 3; i++) begin
      txq.push_back(8'($urandom));
      rdq.push_back(txq[i]);
    end
    m.start();
    addr(own, DIR_READ, 1'b0);
    for (int i = 0; i < 3; i++) begin
      m.xfer(8'hFF, i == 2, r, k);
      chk(r, rdq.pop_front());
    end
    m.stop();
    drain();
    hold_rx = 1'b1;
    m.start();
    addr(own, 1'b0, 1'b0);
    wr(17, 16);
    m.stop();
    hold_rx = 1'b0;
    drain();
    m.q(2);
    chk(8'(rx_valid), 8'h00);
    power_off = 1'b1;
    m.start();
    addr(own, 1'b0, 1'b1);
    chk({6'h00, busy, sda_oe}, 8'h00);
    m.stop();
    test_done();
  end
endmodule // test_two_wire_bus_framing

/* tb/twbf_master.sv */
module twbf_master (
  // Clock
  input wire logic clk_in,
  // Bus lines
  input wire logic scl_line_in,
  input wire logic sda_line_in,
  output logic scl_pull_out,
  output logic sda_pull_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_pull_out = 1'b0;
    sda_pull_out = 1'b0;
  end
  task automatic q(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic rise();
    int k;
    k = 0;
    scl_pull_out = 1'b0;
    while (scl_line_in !== 1'b1 && k < 4000) begin
      @(negedge clk_in);
      k++;
    end
    q(2);
  endtask
  task automatic bit_io(input logic b, output logic r);
    q(2);
    sda_pull_out = !b;
    q(2);
    rise();
    r = sda_line_in;
    q(2);
    scl_pull_out = 1'b1;
  endtask
  task automatic start();
    // Release data while the clock is low, then pull data low with the clock high
    q(2);
    sda_pull_out = 1'b0;
    q(2);
    rise();
    sda_pull_out = 1'b1;
    q(4);
    scl_pull_out = 1'b1;
  endtask
  task automatic stop();
    q(2);
    sda_pull_out = 1'b1;
    q(2);
    rise();
    sda_pull_out = 1'b0;
    q(4);
  endtask
  task automatic xfer(input logic [7:0] d, input logic nak, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(nak, a);
  endtask
endmodule // twbf_master
